/* File: hdl/sfdp_consts.svh */
// Constants for the discoverable-parameter read responder.
`ifndef SFDP_CONSTS_SVH
`define SFDP_CONSTS_SVH

// ----------------------------------------------------------------
// Serial commands and frame lengths
// ----------------------------------------------------------------
`define SFDP_OP_READ 8'h5a
`define SFDP_OP_VOL_WREN 8'h50
`define SFDP_OPCODE_LAST 5'h07
`define SFDP_ADDR_LAST 5'h17
`define SFDP_DUMMY_LAST 5'h07
`define SFDP_BIT_LAST 3'h7

// ----------------------------------------------------------------
// Parameter table contents
// ----------------------------------------------------------------
`define SFDP_SIG_B0 8'h53
`define SFDP_SIG_B1 8'h46
`define SFDP_SIG_B2 8'h44
`define SFDP_SIG_B3 8'h50
`define SFDP_HDR_MINOR 8'h00
`define SFDP_HDR_MAJOR 8'h01
`define SFDP_HEADER_COUNT 8'h00
`define SFDP_RESERVED 8'hff
`define SFDP_PARAM_ID 8'h00
`define SFDP_TBL_MINOR 8'h00
`define SFDP_TBL_MAJOR 8'h01
`define SFDP_TBL_LEN_DW 8'h09
`define SFDP_PTR_B0 8'h30
`define SFDP_PTR_B1 8'h00
`define SFDP_PTR_B2 8'h00
`define SFDP_TBL_ERASE_INFO 8'hed
`define SFDP_TBL_ERASE_OP 8'h20
`define SFDP_FILL 8'hff

// ----------------------------------------------------------------
// Register map and reset values
// ----------------------------------------------------------------
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_ADDR_OFS 12'h008
`define CTRL_ENABLE_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_ACTIVE_BIT 1
`define STATUS_WREN_BIT 2
`define STATUS_REJECT_BIT 3
`define CTRL_ENABLE_RST 1'b1

`endif

/* File: hdl/sfdp_pkg.sv */
// Types shared by the discoverable-parameter read responder.
`default_nettype none
package sfdp_pkg;

  typedef enum logic [2:0] {
    S_CMD = 3'b000,
    S_ADDR = 3'b001,
    S_DUMMY = 3'b010,
    S_DATA = 3'b011,
    S_IGNORE = 3'b100
  } phase_e;

  typedef struct packed {
    phase_e st;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic [8:0] addr;
    logic [2:0] bitn;
    logic miso;
    logic oe;
    logic vol_wren;
    logic rejected;
    logic enable;
    logic sclk_q;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_s;

endpackage
`default_nettype wire

/* File: hdl/sfdp_table.sv */
// Read-only parameter table, 512 locations, combinational lookup.
`include "sfdp_consts.svh"
`default_nettype none
module sfdp_table (
  input wire logic [8:0] addr,
  output logic [7:0] data
);

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  // Unlisted locations fall to the fill value so a host scanning the
  // whole space never sees stale or random data.
  always_comb begin
    unique case (addr)
      // RULE_09 - signature bytes.
      9'h000: data = `SFDP_SIG_B0;
      9'h001: data = `SFDP_SIG_B1;
      9'h002: data = `SFDP_SIG_B2;
      9'h003: data = `SFDP_SIG_B3;
      // RULE_10 - header revision.
      9'h004: data = `SFDP_HDR_MINOR;
      9'h005: data = `SFDP_HDR_MAJOR;
      // RULE_11 - header count, reserved.
      9'h006: data = `SFDP_HEADER_COUNT;
      9'h007: data = `SFDP_RESERVED;
      // RULE_12 - parameter header identity.
      9'h008: data = `SFDP_PARAM_ID;
      9'h009: data = `SFDP_TBL_MINOR;
      9'h00a: data = `SFDP_TBL_MAJOR;
      // RULE_13 - table length words.
      9'h00b: data = `SFDP_TBL_LEN_DW;
      // RULE_14 - table pointer bytes.
      9'h00c: data = `SFDP_PTR_B0;
      9'h00d: data = `SFDP_PTR_B1;
      9'h00e: data = `SFDP_PTR_B2;
      9'h00f: data = `SFDP_RESERVED;
      // RULE_15 - erase info byte; RULE_16 - write-enable select field.
      9'h030: data = `SFDP_TBL_ERASE_INFO;
      // RULE_17 - small erase opcode.
      9'h031: data = `SFDP_TBL_ERASE_OP;
      // RULE_20 - undefined locations fill.
      default: data = `SFDP_FILL;
    endcase
  end

endmodule // sfdp_table
`default_nettype wire

/* File: hdl/sfdp_read_responder.sv */
// Serial discoverable-parameter read responder with an APB control slave.
//
// Behaviour
// RULE_01 - Select low plus opcode 5Ah starts a parameter-table read.
// RULE_02 - Three address bytes then a dummy byte, all sampled on rising clock.
// RULE_03 - After the dummy byte, output table bits, changing on falling clock.
// RULE_04 - Any start address; address advances after each output byte.
// RULE_05 - Parameter space is 512 bytes; reads stay inside it.
// RULE_06 - Address wraps to zero past the top; output continues while selected.
// RULE_07 - Raising select stops output drive and abandons the command immediately.
// RULE_08 - Read arriving during erase, program or write is ignored harmlessly.
// RULE_09 - Bytes 00h-03h return 53h 46h 44h 50h, the signature.
// RULE_10 - Byte 04h returns 00h, byte 05h returns 01h.
// RULE_11 - Byte 06h returns 00h, one header; byte 07h returns FFh.
// RULE_12 - Bytes 08h, 09h, 0Ah return 00h, 00h, 01h.
// RULE_13 - Byte 0Bh returns 09h, table length in words.
// RULE_14 - Bytes 0Ch-0Eh return pointer 000030h low first; 0Fh returns FFh.
// RULE_15 - Table byte 30h returns EDh describing erase and write features.
// RULE_16 - Write-enable field reads 01b; opcode 50h enables volatile status writes.
// RULE_17 - Table byte 31h returns 20h, the small erase opcode.
// RULE_18 - Busy flag is high during self-timed cycles and gates read rejection.
// RULE_19 - Select high enters standby; next selection starts a fresh command.
// RULE_20 - Undefined parameter-space locations return FFh.
// RULE_21 - Dummy byte lasts eight clocks; output stays undriven meanwhile.
`include "sfdp_consts.svh"
`default_nettype none
module sfdp_read_responder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic busy_cycle_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decode shared by the read mux and the write path: {hit, index}.
  function automatic logic [2:0] reg_decode(input logic [11:0] a);
    logic [2:0] d;
    d = 3'h0;
    if (a == `REG_CTRL_OFS) begin
      d = 3'h4;
    end else if (a == `REG_STATUS_OFS) begin
      d = 3'h5;
    end else if (a == `REG_ADDR_OFS) begin
      d = 3'h6;
    end
    return d;
  endfunction

  sfdp_pkg::state_s r;
  sfdp_pkg::state_s n;
  logic rise;
  logic fall;
  logic [7:0] rom_byte;
  logic [2:0] dec;
  logic setup;
  logic access;

  // Clock edges are found by comparing with last cycle's sample, so the
  // serial clock must stay well below half the system clock.
  assign rise = sclk & ~r.sclk_q;
  assign fall = ~sclk & r.sclk_q;
  assign dec = reg_decode(paddr);
  assign setup = psel & ~penable;
  assign access = psel & penable & r.pready;

  sfdp_table u_table (
    .addr(r.addr),
    .data(rom_byte)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // The APB clears come before the serial logic so that a flag set by the
  // serial side in the same cycle overrides the clear.
  always_comb begin
    logic [7:0] opc;
    logic [31:0] rd;
    opc = 8'h00;
    rd = 32'h0000_0000;
    n = r;
    n.sclk_q = sclk;

    // Register read mux, sampled in the setup cycle.
    unique case (dec)
      3'h4: rd[`CTRL_ENABLE_BIT] = r.enable;
      3'h5: begin
        rd[`STATUS_BUSY_BIT] = busy_cycle_flag;
        rd[`STATUS_ACTIVE_BIT] = (r.st == sfdp_pkg::S_DATA);
        rd[`STATUS_WREN_BIT] = r.vol_wren;
        rd[`STATUS_REJECT_BIT] = r.rejected;
      end
      3'h6: rd[8:0] = r.addr;
      default: rd = 32'h0000_0000;
    endcase

    // APB answers one cycle after setup; no wait states.
    n.pready = setup;
    n.pslverr = setup & ~dec[2];
    n.prdata = setup ? rd : 32'h0000_0000;
    if (access & pwrite & dec[2]) begin
      if (dec[1:0] == 2'h0) begin
        n.enable = pwdata[`CTRL_ENABLE_BIT];
      end
      if (dec[1:0] == 2'h1) begin
        if (pwdata[`STATUS_WREN_BIT]) begin
          n.vol_wren = 1'b0;
        end
        if (pwdata[`STATUS_REJECT_BIT]) begin
          n.rejected = 1'b0;
        end
      end
    end

    // RULE_07 - deselect abandons command; RULE_19 - standby.
    if (cs_n) begin
      n.st = sfdp_pkg::S_CMD;
      n.cnt = 5'h00;
      n.oe = 1'b0;
    end else begin
      unique case (r.st)
        sfdp_pkg::S_CMD: begin
          if (rise) begin
            // RULE_02 - sample on rising.
            n.sh = {r.sh[22:0], mosi};
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == `SFDP_OPCODE_LAST) begin
              n.cnt = 5'h00;
              opc = {r.sh[6:0], mosi};
              n.st = sfdp_pkg::S_IGNORE;
              // RULE_01 - read opcode decode.
              if (r.enable && opc == `SFDP_OP_READ) begin
                // RULE_08 - busy rejects read; RULE_18 - busy gating.
                if (busy_cycle_flag) begin
                  n.rejected = 1'b1;
                end else begin
                  n.st = sfdp_pkg::S_ADDR;
                end
              end
              // RULE_16 - volatile write enable.
              if (r.enable && opc == `SFDP_OP_VOL_WREN && !busy_cycle_flag) begin
                n.vol_wren = 1'b1;
              end
            end
          end
        end
        sfdp_pkg::S_ADDR: begin
          if (rise) begin
            n.sh = {r.sh[22:0], mosi};
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == `SFDP_ADDR_LAST) begin
              // RULE_04 - any start address; RULE_05 - 512-byte space.
              n.addr = {r.sh[7:0], mosi};
              n.cnt = 5'h00;
              n.st = sfdp_pkg::S_DUMMY;
            end
          end
        end
        sfdp_pkg::S_DUMMY: begin
          // RULE_21 - eight dummy clocks.
          if (rise) begin
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == `SFDP_DUMMY_LAST) begin
              n.cnt = 5'h00;
              n.bitn = 3'h0;
              n.st = sfdp_pkg::S_DATA;
            end
          end
        end
        sfdp_pkg::S_DATA: begin
          // RULE_03 - drive on falling.
          if (fall) begin
            n.miso = rom_byte[~r.bitn];
            n.oe = 1'b1;
            n.bitn = r.bitn + 3'h1;
            // RULE_04 - advance address; RULE_06 - 9-bit wrap.
            if (r.bitn == `SFDP_BIT_LAST) begin
              n.addr = r.addr + 9'h001;
            end
          end
        end
        sfdp_pkg::S_IGNORE: begin
          n.oe = 1'b0;
        end
        default: begin
          n.st = sfdp_pkg::S_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // The sampled clock resets low; in mode 3 the first cycle after reset
  // may see a spurious rise, harmless because select is then high.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.enable <= `CTRL_ENABLE_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign miso = r.miso;
  assign miso_oe = r.oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_deselect_oe: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    cs_n |=> !miso_oe && r.st == sfdp_pkg::S_CMD)
    else $error("output still driven after deselect");

  chk_standby_fresh: assert property (@(posedge clk) disable iff (!reset_n) // RULE_19
    (cs_n ##1 !cs_n) |-> r.cnt == 5'h00 && r.st == sfdp_pkg::S_CMD)
    else $error("command not fresh on new selection");

  chk_busy_reject: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    (!cs_n && rise && r.st == sfdp_pkg::S_CMD && r.cnt == 5'h07
     && r.enable && {r.sh[6:0], mosi} == 8'h5a && busy_cycle_flag)
    |=> r.st == sfdp_pkg::S_IGNORE && r.rejected)
    else $error("read accepted while busy");

  chk_read_accept: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    (!cs_n && rise && r.st == sfdp_pkg::S_CMD && r.cnt == 5'h07 && r.enable
     && {r.sh[6:0], mosi} == 8'h5a && !busy_cycle_flag)
    |=> r.st == sfdp_pkg::S_ADDR)
    else $error("read opcode not decoded");

  chk_out_on_fall: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    $changed(r.miso) |-> $past(fall))
    else $error("output changed off falling clock");

  chk_addr_advance: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    (!cs_n && fall && r.st == sfdp_pkg::S_DATA && r.bitn == 3'h7)
    |=> r.addr == $past(r.addr) + 9'h001)
    else $error("address did not advance after byte");

  chk_dummy_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RULE_21
    (r.st == sfdp_pkg::S_DUMMY) |-> !miso_oe && r.cnt <= 5'h07)
    else $error("dummy phase drives output or overruns");

  chk_data_entry: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    (r.st == sfdp_pkg::S_DATA && $past(r.st) != sfdp_pkg::S_DATA)
    |-> $past(r.st) == sfdp_pkg::S_DUMMY && $past(r.cnt) == 5'h07)
    else $error("data phase entered early");

  chk_signature_byte: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    (r.addr == 9'h000) |-> rom_byte == 8'h53)
    else $error("signature byte wrong");

  chk_wren_set: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
    (!cs_n && rise && r.st == sfdp_pkg::S_CMD && r.cnt == 5'h07 && r.enable
     && {r.sh[6:0], mosi} == 8'h50 && !busy_cycle_flag) |=> r.vol_wren)
    else $error("volatile write enable not set");

  chk_addr_load: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    (!cs_n && rise && r.st == sfdp_pkg::S_ADDR && r.cnt == 5'h17)
    |=> r.addr == {$past(r.sh[7:0]), $past(mosi)})
    else $error("start address not loaded from last address bits");

  chk_addr_wrap: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    (!cs_n && fall && r.st == sfdp_pkg::S_DATA && r.bitn == 3'h7 && r.addr == 9'h1ff)
    |=> r.addr == 9'h000)
    else $error("address did not wrap to zero");

  chk_fill_blank: assert property (@(posedge clk) disable iff (!reset_n) // RULE_20
    (r.addr inside {[9'h010:9'h02f]} || r.addr > 9'h031)
    |-> rom_byte == 8'hff)
    else $error("undefined location not blank");

  chk_oe_data_only: assert property (@(posedge clk) disable iff (!reset_n) // RULE_21
    miso_oe |-> r.st == sfdp_pkg::S_DATA)
    else $error("output driven outside data phase");

  chk_ignore_quiet: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    (r.st == sfdp_pkg::S_IGNORE) |-> !miso_oe)
    else $error("ignored command drives output");

  chk_rise_only: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    (!cs_n && !rise && r.st == sfdp_pkg::S_ADDR)
    |=> r.cnt == $past(r.cnt) && r.st == sfdp_pkg::S_ADDR)
    else $error("address bit taken without rising clock");

endmodule // sfdp_read_responder
`default_nettype wire

/* File: sim/spi_host_model.sv */
// Behavioural serial host that clocks frames into the responder.
`default_nettype none
module spi_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic oe_seen;
  logic idle;
  logic miso_seen;
  // An undriven output shows the inverse of its last bit, so stale data fails.
  assign miso_seen = miso_oe ? miso : ~miso;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    idle = 1'b1;
    oe_seen = 1'b0;
  end
  // The released data line toggles, so a stale bit never looks valid.
  always @(posedge clk) begin
    if (idle) begin
      mosi <= ~mosi;
    end
  end
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // select, header bits
  // Each phase lasts four clocks, well above the two-clock minimum.
  task automatic xfer(input logic [39:0] hdr, input int nhdr, input int ndat);
    logic [7:0] b;
    b = 8'h00;
    idle = 1'b0;
    rx_q.delete();
    oe_seen = 1'b0;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < nhdr + ndat; i++) begin
      if (i < nhdr) begin
        mosi <= hdr[39 - i];
      end else begin
        mosi <= ~mosi;
      end
      repeat (4) @(posedge clk);
      if (i >= nhdr) begin
        b = {b[6:0], miso_seen};
        oe_seen = oe_seen | miso_oe;
        if ((i - nhdr) % 8 == 7) begin
          rx_q.push_back(b);
        end
      end
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
    idle = 1'b1;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: sim/sfdp_read_responder_bench.sv */
// Self-checking bench for the discoverable-parameter read responder.
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module sfdp_read_responder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic sclk, cs_n, mosi, miso, miso_oe, busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00,
    8'hff, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};

  sfdp_read_responder i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .busy_cycle_flag(busy));
  spi_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  // Clock of 20 ns and a cycle ceiling so a hang still ends the run.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Expected table byte: header, two feature bytes, all else blank.
  function automatic logic [7:0] exp_byte(input logic [8:0] a);
    if (a < 9'h010) return HDR[a[3:0]];
    if (a == 9'h030) return 8'hed;
    if (a == 9'h031) return 8'h20;
    return 8'hff;
  endfunction
  // One APB transfer; a silent slave is caught by the cycle ceiling.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic read_chk(input logic [23:0] a, input int n);
    i_host.xfer({8'h5a, a, 8'h00}, 40, 8 * n);
    `CHK(i_host.oe_seen, 1'b1)
    `CHK(i_host.rx_q.size(), n)
    for (int k = 0; k < n; k++) begin
      `CHK(i_host.rx_q[k], exp_byte(9'(a + k)))
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    busy = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h00000001)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(err, 1'b1)
    $display("registers done");
    read_chk(24'h000000, 16);
    read_chk(24'h00002e, 4);
    read_chk(24'hff01fe, 3);
    $display("table reads done");
    i_host.xfer({8'h5a, 24'h0, 8'h00}, 40, 13);
    `CHK(miso_oe, 1'b0)
    `CHK(i_host.rx_q.size(), 1)
    read_chk(24'h000008, 2);
    $display("abort done");
    busy <= 1'b1;
    i_host.xfer({8'h5a, 24'h0, 8'h00}, 40, 16);
    `CHK(i_host.oe_seen, 1'b0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[3:0], 4'b1001)
    busy <= 1'b0;
    apb(1'b1, 12'h004, 32'h8);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[3:0], 4'b0000)
    $display("busy done");
    i_host.xfer({8'h50, 32'h0}, 8, 0);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(1'b1, 12'h000, 32'h0);
    i_host.xfer({8'h5a, 24'h0, 8'h00}, 40, 8);
    `CHK(i_host.oe_seen, 1'b0)
    apb(1'b1, 12'h000, 32'h1);
    read_chk(24'h000030, 1);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h00000031)
    // Status is read while the data phase runs, so the active bit is seen.
    fork
      i_host.xfer({8'h5a, 24'h0, 8'h00}, 40, 16);
      begin
        repeat (400) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
      end
    join
    `CHK(rd[3:0], 4'b0110)
    `CHK(i_host.rx_q[1], 8'h46)
    $display("commands done");
    finish_test();
  end
endmodule // sfdp_read_responder_bench
`default_nettype wire
